/* File: hw/floppy_status_map.svh */
// register offsets, bit positions and reset values of the floppy status and output registers
`ifndef FLOPPY_STATUS_MAP_SVH
`define FLOPPY_STATUS_MAP_SVH
`define OFS_STATUS_A 3'h0
`define OFS_STATUS_B 3'h1
`define OFS_DRIVE_OUTPUT 3'h2
`define DRVOUT_RESET 8'h00
`define DRVOUT_SEL_LO 0
`define DRVOUT_SEL_HI 1
`define DRVOUT_SOFT_RESET_N 2
`define DRVOUT_DMA_ENABLE 3
`define DRVOUT_MOTOR_LO 4
`define DRVOUT_MOTOR_HI 7
`define DRVOUT_MOTOR_COUNT 4
`define SOFT_RESET_MIN_NS 100
`define CLK_PERIOD_NS 50
`define SOFT_RESET_MIN_CYC ((`SOFT_RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_IDLE 8'h00
`define MODE_SEL_A 2'h3
`define MODE_SEL_B 2'h1
`define FORCE_PROTECT_BIT 0
`define STA_DIR_N 0
`define STA_PROTECT 1
`define STA_INDEX 2
`define STA_SIDE_N 3
`define STA_TRACK0 4
`define STA_STEP 5
`define STA_DRQ 6
`define STA_IRQ 7
`define STB_MOTOR0 0
`define STB_MOTOR1 1
`define STB_WRITE_GATE 2
`define STB_RD_TOGGLE 3
`define STB_WD_TOGGLE 4
`define STB_SEL0 5
`define STB_ONES_LO 6
`define STB_ONES_HI 7
`define STB_ONES 2'h3
`define STC_SEL2_N 0
`define STC_SEL3_N 1
`define STC_WRITE_GATE 2
`define STC_RDATA 3
`define STC_WDATA 4
`define STC_SEL0_N 5
`define STC_SEL1_N 6
`define STC_DRIVE2_N 7
`endif

/* File: hw/floppy_status_pkg.sv */
// types of the floppy status and output registers
package floppy_status_pkg;
  typedef enum logic [2:0] {
    MODE_A = 3'b001,
    MODE_B = 3'b010,
    MODE_C = 3'b100
  } compat_mode_type;
endpackage

/* File: hw/floppy_status_and_output_regs.sv */
// status registers A and B and the drive output register of the floppy controller
//
// Summary of operation
// - mode C status A bit 0 reads 0 when stepping inward, 1 outward.
// - mode C status A bit 1 reads 1 for protected disk, including forced protect.
// - mode C status A bit 2 is index, bit 4 is track zero, active high.
// - mode C status A bit 3 reads 0 when side 1 selected.
// - mode C status A bit 5 latches step active; cleared by status read or resets.
// - mode C status A bit 6 is DRQ, bit 7 is floppy interrupt level.
// - status B is read only; in mode A its read leaves the bus undriven.
// - mode B status B bits 0,1 motors, bit 2 write gate; hardware reset only.
// - mode B status B bits 3,4 toggle on read data and write data trailing edges.
// - mode B status B bit 5 mirrors drive select bit 0.
// - mode B status B bits 6 and 7 read as one.
// - mode C status B gives active low drive selects and second drive present.
// - mode C status B bit 2 latches write gate rising, clears on status read.
// - mode C status B bit 3 latches read data trailing edge, clears on status read.
// - mode C status B bit 4 latches write data trailing edge, regardless of write gate.
// - drive output register is read/write, resets to zero, untouched by soft reset.
// - drive select field decodes to exactly one of four selects.
// - writing 0 to soft reset bit holds controller reset until 1 written.
// - soft reset lasts at least 100 ns; clear-then-set writes suffice.
// - modes A and C: dma enable gates DRQ, DACK, TC and interrupt.
// - mode B: DMA and interrupt pins always enabled; reset clears dma enable.
// - drive output bit 4 drives motor 0.
// - ident and density bits choose mode A, B or C.
// - drive output bits 5,6,7 drive motors 1,2,3.
`timescale 1ns/1ps
`default_nettype none
`include "floppy_status_map.svh"
module floppy_status_and_output_regs
  import floppy_status_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [2:0] hostAddr,
  input wire logic hostRead,
  input wire logic hostWrite,
  input wire logic [7:0] hostWriteData,
  output logic [7:0] hostReadData,
  output logic hostDataOe_n,
  input wire logic inputStatusRead,
  input wire logic ident_cfg,
  input wire logic density_cfg,
  input wire logic [1:0] force_status_cfg,
  input wire logic stepDirIn,
  input wire logic stepOut,
  input wire logic writeProtectIn,
  input wire logic indexIn,
  input wire logic track_zero_in,
  input wire logic head_side_sel,
  input wire logic write_gate,
  input wire logic read_data_in,
  input wire logic write_data_out,
  input wire logic second_drive_present_n,
  input wire logic drqIn,
  input wire logic floppyIrqIn,
  input wire logic dackIn_n,
  input wire logic tcIn,
  output logic drq,
  output logic drqOe_n,
  output logic floppy_irq,
  output logic floppyIrqOe_n,
  output logic dackGated_n,
  output logic tcGated,
  output logic [3:0] drive_sel,
  output logic [3:0] motorOn,
  output logic dma_enable,
  output logic softResetActive
);

  // ***************************************************
  // mode selection
  // ***************************************************
  compat_mode_type mode;
  always_comb begin
    unique case ({ident_cfg, density_cfg})
      `MODE_SEL_A: begin
        mode = MODE_A;
      end
      `MODE_SEL_B: begin
        mode = MODE_B;
      end
      default: begin
        mode = MODE_C;
      end
    endcase
  end

  // ***************************************************
  // address decode
  // ***************************************************

  function automatic logic isOffset(input logic [2:0] addr, input logic [2:0] offset);
    isOffset = (addr == offset);
  endfunction

  function automatic logic isStatusOffset(input logic [2:0] addr);
    isStatusOffset = isOffset(addr, `OFS_STATUS_A) || isOffset(addr, `OFS_STATUS_B);
  endfunction

  // ***************************************************
  // drive output register
  // ***************************************************
  logic [7:0] driveOutputReg;
  logic driveOutWrite;
  assign driveOutWrite = hostWrite && isOffset(hostAddr, `OFS_DRIVE_OUTPUT);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      driveOutputReg <= `DRVOUT_RESET;
    end else if (driveOutWrite) begin
      driveOutputReg <= hostWriteData;
    end
  end

  // soft reset held while the bit is 0, then stretched to the minimum width
  logic [3:0] softCount;
  logic softHeld;
  logic softStretch;
  assign softHeld = !driveOutputReg[`DRVOUT_SOFT_RESET_N];

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      softCount <= 4'h0;
    end else if (softHeld) begin
      softCount <= 4'(`SOFT_RESET_MIN_CYC);
    end else if (softStretch) begin
      softCount <= softCount - 4'h1;
    end
  end

  assign softStretch = (softCount != 4'h0);
  assign softResetActive = softHeld || softStretch;

  // ***************************************************
  // drive select and motors
  // ***************************************************

  function automatic logic [3:0] decodeSelect(input logic [1:0] sel);
    decodeSelect = 4'h1 << sel;
  endfunction

  assign drive_sel = decodeSelect(driveOutputReg[`DRVOUT_SEL_HI:`DRVOUT_SEL_LO]);

  // one motor output per enable bit
  for (genvar m = 0; m < `DRVOUT_MOTOR_COUNT; m++) begin : gen_motor
    assign motorOn[m] = driveOutputReg[`DRVOUT_MOTOR_LO + m];
  end

  assign dma_enable = driveOutputReg[`DRVOUT_DMA_ENABLE];

  // ***************************************************
  // DMA and interrupt pin gating
  // ***************************************************
  logic pinsEnabled;
  assign pinsEnabled = (mode == MODE_B) || dma_enable;

  // pass-through levels, released by the output enables below
  assign drq = drqIn;
  assign floppy_irq = floppyIrqIn;

  always_comb begin
    drqOe_n = 1'b1;
    floppyIrqOe_n = 1'b1;
    dackGated_n = 1'b1;
    tcGated = 1'b0;
    if (pinsEnabled) begin
      drqOe_n = 1'b0;
      floppyIrqOe_n = 1'b0;
      dackGated_n = dackIn_n;
      tcGated = tcIn;
    end
  end

  // ***************************************************
  // edge detection and latched flags
  // ***************************************************
  // previous input levels for edge detection
  logic stepPrev;
  logic wgPrev;
  logic rdPrev;
  logic wdPrev;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      stepPrev <= 1'b0;
    end else begin
      stepPrev <= stepOut;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wgPrev <= 1'b0;
    end else begin
      wgPrev <= write_gate;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rdPrev <= 1'b0;
    end else begin
      rdPrev <= read_data_in;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wdPrev <= 1'b0;
    end else begin
      wdPrev <= write_data_out;
    end
  end

  logic stepRise;
  logic wgRise;
  logic rdFall;
  logic wdFall;

  assign stepRise = stepOut && !stepPrev;
  assign wgRise = write_gate && !wgPrev;
  assign rdFall = !read_data_in && rdPrev;
  assign wdFall = !write_data_out && wdPrev;

  // ***************************************************
  // read-cleared flags
  // ***************************************************

  // set wins over the clear by read
  logic stepFlag;
  logic wgFlag;
  logic rdFlag;
  logic wdFlag;

  always_ff @(posedge core_clk) begin
    if (!reset_n || softResetActive) begin
      stepFlag <= 1'b0;
    end else if (stepRise) begin
      stepFlag <= 1'b1;
    end else if (inputStatusRead) begin
      stepFlag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wgFlag <= 1'b0;
    end else if (wgRise) begin
      wgFlag <= 1'b1;
    end else if (inputStatusRead) begin
      wgFlag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rdFlag <= 1'b0;
    end else if (rdFall) begin
      rdFlag <= 1'b1;
    end else if (inputStatusRead) begin
      rdFlag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wdFlag <= 1'b0;
    end else if (wdFall) begin
      wdFlag <= 1'b1;
    end else if (inputStatusRead) begin
      wdFlag <= 1'b0;
    end
  end

  // ***************************************************
  // mode B toggles
  // ***************************************************

  logic rdToggle;
  logic wdToggle;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rdToggle <= 1'b0;
    end else if (rdFall) begin
      rdToggle <= !rdToggle;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wdToggle <= 1'b0;
    end else if (wdFall) begin
      wdToggle <= !wdToggle;
    end
  end

  // ***************************************************
  // read data assembly
  // ***************************************************
  logic [7:0] statusA;
  logic [7:0] statusB;
  logic [7:0] next_readData;
  logic protect;
  assign protect = writeProtectIn || force_status_cfg[`FORCE_PROTECT_BIT];

  always_comb begin
    statusA = `READ_IDLE;
    statusA[`STA_DIR_N] = !stepDirIn;
    statusA[`STA_PROTECT] = protect;
    statusA[`STA_INDEX] = indexIn;
    statusA[`STA_SIDE_N] = !head_side_sel;
    statusA[`STA_TRACK0] = track_zero_in;
    statusA[`STA_STEP] = stepFlag;
    statusA[`STA_DRQ] = drqIn;
    statusA[`STA_IRQ] = floppyIrqIn;
  end

  // ***************************************************
  // status B
  // ***************************************************

  always_comb begin
    statusB = `READ_IDLE;
    if (mode == MODE_B) begin
      statusB[`STB_MOTOR0] = motorOn[0];
      statusB[`STB_MOTOR1] = motorOn[1];
      statusB[`STB_WRITE_GATE] = write_gate;
      statusB[`STB_RD_TOGGLE] = rdToggle;
      statusB[`STB_WD_TOGGLE] = wdToggle;
      statusB[`STB_SEL0] = driveOutputReg[`DRVOUT_SEL_LO];
      statusB[`STB_ONES_HI:`STB_ONES_LO] = `STB_ONES;
    end else begin
      statusB[`STC_SEL2_N] = !drive_sel[2];
      statusB[`STC_SEL3_N] = !drive_sel[3];
      statusB[`STC_WRITE_GATE] = wgFlag;
      statusB[`STC_RDATA] = rdFlag;
      statusB[`STC_WDATA] = wdFlag;
      statusB[`STC_SEL0_N] = !drive_sel[0];
      statusB[`STC_SEL1_N] = !drive_sel[1];
      statusB[`STC_DRIVE2_N] = second_drive_present_n;
    end
  end

  // ***************************************************
  // host read port
  // ***************************************************

  always_comb begin
    unique case (hostAddr)
      `OFS_STATUS_A: next_readData = statusA;
      `OFS_STATUS_B: next_readData = statusB;
      `OFS_DRIVE_OUTPUT: next_readData = driveOutputReg;
      default: next_readData = `READ_IDLE;
    endcase
  end

  logic readDrive;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      hostReadData <= `READ_IDLE;
    end else begin
      hostReadData <= next_readData;
    end
  end

  // status reads in mode A leave the bus undriven
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      readDrive <= 1'b0;
    end else begin
      readDrive <= hostRead && (isOffset(hostAddr, `OFS_DRIVE_OUTPUT) ||
                   (mode != MODE_A && isStatusOffset(hostAddr)));
    end
  end
  assign hostDataOe_n = !readDrive;

endmodule
`default_nettype wire

/* File: testbench/floppy_regs_chk.sv */
// port checker of the floppy status and output registers
`timescale 1ns/1ps
`default_nettype none
module floppy_regs_chk (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [2:0] hostAddr,
  input wire logic hostRead,
  input wire logic hostWrite,
  input wire logic [7:0] hostWriteData,
  input wire logic [7:0] hostReadData,
  input wire logic hostDataOe_n,
  input wire logic ident_cfg,
  input wire logic density_cfg,
  input wire logic drqOe_n,
  input wire logic dackGated_n,
  input wire logic [3:0] drive_sel,
  input wire logic [3:0] motorOn,
  input wire logic dma_enable,
  input wire logic softResetActive
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence driveOutWrite; hostWrite && hostAddr == 3'h2; endsequence
  sequence modeB2; (!ident_cfg && density_cfg) [*2]; endsequence
  sel_one_hot_a: assert property ($onehot(drive_sel)) else $error("select");
  sel_code_a: assert property (driveOutWrite |=> drive_sel == 4'h1 << $past(hostWriteData[1:0]))
    else $error("code");
  motor_bits_a: assert property (driveOutWrite |=> motorOn == $past(hostWriteData[7:4]))
    else $error("motor");
  soft_enter_a: assert property (driveOutWrite ##0 !hostWriteData[2] |=> softResetActive)
    else $error("soft");
  soft_width_a: assert property ($rose(softResetActive) |=> softResetActive [*2]) else $error("width");
  mode_a_float_a: assert property (hostRead && hostAddr <= 3'h1 && ident_cfg && density_cfg |=> hostDataOe_n)
    else $error("float");
  reserved_ones_a: assert property (hostRead && hostAddr == 3'h1 && !ident_cfg && density_cfg
    |=> !hostDataOe_n && hostReadData[7:6] == 2'h3) else $error("ones");
  pins_live_a: assert property (modeB2 |-> !drqOe_n) else $error("live");
  dma_gate_a: assert property ((!dma_enable && !(!ident_cfg && density_cfg)) [*2] |-> drqOe_n && dackGated_n)
    else $error("gate");
endmodule
bind floppy_status_and_output_regs floppy_regs_chk u_chk (.core_clk, .reset_n, .hostAddr, .hostRead, .hostWrite,
  .hostWriteData, .hostReadData, .hostDataOe_n, .ident_cfg, .density_cfg, .drqOe_n, .dackGated_n, .drive_sel,
  .motorOn, .dma_enable, .softResetActive);
`default_nettype wire

/* File: testbench/floppy_drive_model.sv */
// drive side model making read data pulses
`timescale 1ns/1ps
`default_nettype none
module floppy_drive_model (
  input wire logic core_clk,
  input wire logic pulseReq,
  output logic read_data_in
);
  logic [1:0] width = 2'h0;
  // each pulse is held two clocks
  always @(posedge core_clk) begin
    if (pulseReq)
      width <= 2'h2;
    else if (width != 2'h0)
      width <= width - 2'h1;
  end
  assign read_data_in = (width != 2'h0);
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench of the floppy status and output registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 0, reset_n = 0, hostRead = 0, hostWrite = 0, inputStatusRead = 0, ident_cfg = 0;
  logic density_cfg = 1, stepOut = 0, write_gate = 0, write_data_out = 0, dackIn_n = 1, rdReq = 0;
  logic stepDirIn = 1, writeProtectIn = 1, indexIn = 1, track_zero_in = 0, head_side_sel = 1;
  logic [2:0] hostAddr = 0;
  logic [7:0] hostWriteData = 0, hostReadData, d;
  logic [3:0] drive_sel, motorOn;
  logic hostDataOe_n, read_data_in, drq, drqOe_n, floppy_irq, floppyIrqOe_n, dackGated_n, tcGated, dma_enable, oe;
  logic softResetActive;
  int fails = 0, comparisons = 0;
  always #25 core_clk = ~core_clk;
  floppy_drive_model drive (.core_clk, .pulseReq(rdReq), .read_data_in);
  floppy_status_and_output_regs DUT (.core_clk, .reset_n, .hostAddr, .hostRead, .hostWrite, .hostWriteData,
    .hostReadData, .hostDataOe_n, .inputStatusRead, .ident_cfg, .density_cfg, .force_status_cfg(2'h0),
    .stepDirIn, .stepOut, .writeProtectIn, .indexIn, .track_zero_in, .head_side_sel,
    .write_gate, .read_data_in, .write_data_out, .second_drive_present_n(1'b0), .drqIn(1'b1), .floppyIrqIn(1'b0),
    .dackIn_n, .tcIn(1'b0), .drq, .drqOe_n, .floppy_irq, .floppyIrqOe_n, .dackGated_n, .tcGated, .drive_sel,
    .motorOn, .dma_enable, .softResetActive);
  task tick; @(negedge core_clk); endtask
  task check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task wr(input logic [2:0] a, input logic [7:0] v);
    hostAddr = a;
    hostWriteData = v;
    hostWrite = 1;
    tick;
    hostWrite = 0;
    tick;
  endtask
  task rd(input logic [2:0] a);
    hostAddr = a;
    hostRead = 1;
    tick;
    hostRead = 0;
    d = hostReadData;
    oe = hostDataOe_n;
    tick;
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    tick;
    s = 0;
    repeat (4) tick;
  endtask
  task t_reset;
    rd(3'h2);
    check(d, 8'h00);
    check({4'h0, drive_sel}, 8'h01);
    check({6'h0, softResetActive, dma_enable}, 8'h02);
  endtask
  task t_mode_b;
    wr(3'h2, 8'h35);
    write_gate = 1;
    pulse(rdReq);
    rd(3'h1);
    check(d, 8'hEF);
    pulse(rdReq);
    pulse(write_data_out);
    rd(3'h1);
    check(d, 8'hF7);
    check({7'h0, drqOe_n}, 8'h00);
    write_gate = 0;
  endtask
  task t_dor;
    logic [7:0] v [4] = '{8'h1C, 8'h2D, 8'h4E, 8'h8F};
    foreach (v[i]) begin
      wr(3'h2, v[i]);
      rd(3'h2);
      check(d, v[i]);
      check({4'h0, drive_sel}, 8'h01 << v[i][1:0]);
      check({4'h0, motorOn}, {4'h0, v[i][7:4]});
    end
  endtask
  task t_soft;
    int n;
    wr(3'h2, 8'h18);
    repeat (4) tick;
    check({3'h0, softResetActive, motorOn}, 8'h11);
    wr(3'h2, 8'h1C);
    n = 0;
    while (softResetActive !== 1'b0 && n < 8) begin
      tick;
      n++;
    end
    check(n < 8, 8'h01);
    if (n >= 8) end_sim;
    rd(3'h2);
    check(d, 8'h1C);
  endtask
  task t_mode_c;
    density_cfg = 0;
    wr(3'h2, 8'h0E);
    pulse(inputStatusRead);
    pulse(stepOut);
    pulse(write_gate);
    pulse(rdReq);
    pulse(write_data_out);
    rd(3'h0);
    check(d, 8'h66);
    rd(3'h1);
    check(d, 8'h7E);
    pulse(inputStatusRead);
    rd(3'h0);
    check(d, 8'h46);
    rd(3'h1);
    check(d, 8'h62);
    stepDirIn = 0;
    writeProtectIn = 0;
    indexIn = 0;
    track_zero_in = 1;
    head_side_sel = 0;
    rd(3'h0);
    check(d, 8'h59);
  endtask
  task t_mode_a;
    ident_cfg = 1;
    density_cfg = 1;
    dackIn_n = 0;
    wr(3'h2, 8'h04);
    rd(3'h1);
    check({5'h0, oe, dackGated_n, drqOe_n}, 8'h07);
    wr(3'h2, 8'h0C);
    check({6'h0, drqOe_n, dackGated_n}, 8'h00);
  endtask
  initial begin
    repeat (3) tick;
    reset_n = 1;
    t_reset;
    t_mode_b;
    t_dor;
    t_soft;
    t_mode_c;
    t_mode_a;
    end_sim;
  end
endmodule
`default_nettype wire
